// ---- include/ftg_regs.svh ----
`ifndef FTG_REGS_SVH
`define FTG_REGS_SVH

// Register indices; the APB byte address is four times the index.
`define FTG_IDX_BANK_CTRL 10'h001
`define FTG_IDX_FAN_MODE 10'h002
`define FTG_IDX_MISC_CTRL 10'h003
`define FTG_IDX_SPEED_EN 10'h007
`define FTG_IDX_SPEED_CFG 10'h008
`define FTG_IDX_PIN_CFG_LO 10'h009
`define FTG_IDX_UNLOCK 10'h07B
`define FTG_IDX_STATUS 10'h07C

// Reset values.
`define FTG_RST_FAN_MODE 8'h80
`define FTG_RST_MISC_CTRL 8'h00
`define FTG_RST_SPEED_EN 8'h00
`define FTG_RST_SPEED_CFG 8'h0F
`define FTG_RST_PIN_CFG_LO 8'h00

// Fan mode register fields.
`define FTG_B_FAST 0
`define FTG_B_PWM_MODE 2
`define FTG_B_BOOST1 3
`define FTG_B_BOOST2 4
`define FTG_B_FULL 5
`define FTG_B_PULSES_LSB 6
`define FTG_B_PULSES_MSB 7

// Miscellaneous control register fields.
`define FTG_B_PIN_EN 0
`define FTG_B_SCL_TO 1
`define FTG_B_SDA_TO 2
`define FTG_B_VOLT_ID_LOW 3
`define FTG_B_THERMAL_LOW 4
`define FTG_B_CI_CLR 5
`define FTG_B_XOR 6
`define FTG_B_VCORE 7

// Bank control register fields and the unlock key.
`define FTG_B_LOCK 6
`define FTG_B_SWRST 7
`define FTG_UNLOCK_KEY 8'h6D
`define FTG_SPEED_CFG_MASK 8'h0F

// Measurement timing.
`define FTG_CLK_MHZ 100
`define FTG_MEAS_PERIOD_MS 1000
`define FTG_FAST_DIV 4

`endif

// ---- include/ftg_pkg.sv ----
package ftg_pkg;

  // Register selected by an APB address.
  typedef enum logic [3:0] {
    FTG_SEL_NONE = 4'h0,
    FTG_SEL_BANK_CTRL = 4'h1,
    FTG_SEL_FAN_MODE = 4'h2,
    FTG_SEL_MISC_CTRL = 4'h3,
    FTG_SEL_SPEED_EN = 4'h4,
    FTG_SEL_SPEED_CFG = 4'h5,
    FTG_SEL_PIN_CFG_LO = 4'h6,
    FTG_SEL_UNLOCK = 4'h7,
    FTG_SEL_STATUS = 4'h8
  } ftg_sel_t;

  typedef logic [7:0] ftg_byte_t;

endpackage : ftg_pkg

// ---- core/ftg_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser: the output follows only once the second and
// third stages agree, so a value caught mid-transition is never passed on.
module ftg_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // The first stage feeds the second stage only.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a bit only where the last two stages agree.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      level_o <= '0;
    end
    else
    begin
      level_o <= (s2_q & s3_q) | (level_o & (s2_q | s3_q));
    end
  end

endmodule : ftg_sync3

`default_nettype wire

// ---- core/ftg_cfg_regs.sv ----
// Operation
// - Fast bit raises measurement rate to four per second; here only while the mode bit selects low frequency PWM.
// - Mode bit picks low or high frequency PWM.
// - Boost one clear lets regulator one force full.
// - Boost two clear lets regulator two force full.
// - Full speed bit forces every fan full.
// - Pulse field selects pulses one to four.
// - Bit zero enables general purpose pins.
// - Bit one enables clock line timeout.
// - Bit two enables data line timeout.
// - Bits three, four select low input thresholds.
// - Intrusion clear bit self clears, reads zero.
// - Bit six enables XOR tree test.
// - Per input speed measurement enables, reset zero.
// - Pair continuous measurement bits default to one.
// - Upper speed config bits read only zero.
// - Even pin bits set polarity, default low.
// - Odd pin bits set direction, default input.
// - Fan mode resets 0x80; lockable, soft resettable.
// - Lock bit freezes registers until power cycle.
//
// Decided for this implementation: the APB interface to the registers.
`include "ftg_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ftg_cfg_regs #(
  parameter int unsigned MEAS_CYCLES = `FTG_MEAS_PERIOD_MS * `FTG_CLK_MHZ * 1000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic regulator_one_hot_in,
  input wire logic regulator_two_hot_in,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  input wire logic [3:0] gpio_level_i,
  output logic [3:0] gpio_state_o,
  output logic fan_full_speed_o,
  output logic pwm_high_freq_o,
  output logic [2:0] speed_pulse_count_o,
  output logic measure_tick_o,
  output logic [7:0] fan_speed_input_enable_o,
  output logic [7:0] continuous_measure_o,
  output logic general_pin_enable_o,
  output logic scl_timeout_en_o,
  output logic sda_timeout_en_o,
  output logic voltage_id_low_level_sel,
  output logic thermal_in_low_level_sel,
  output logic intrusion_latch_clear,
  output logic xor_tree_en_o,
  output logic vcore_low_en_o,
  output logic lock_o
);
  import ftg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Maps a byte address to a register; misaligned words select nothing.
  function automatic ftg_sel_t decode(input logic [11:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    if (a[1:0] != 2'b00)
      decode = FTG_SEL_NONE;
    else if (idx == `FTG_IDX_BANK_CTRL)
      decode = FTG_SEL_BANK_CTRL;
    else if (idx == `FTG_IDX_FAN_MODE)
      decode = FTG_SEL_FAN_MODE;
    else if (idx == `FTG_IDX_MISC_CTRL)
      decode = FTG_SEL_MISC_CTRL;
    else if (idx == `FTG_IDX_SPEED_EN)
      decode = FTG_SEL_SPEED_EN;
    else if (idx == `FTG_IDX_SPEED_CFG)
      decode = FTG_SEL_SPEED_CFG;
    else if (idx == `FTG_IDX_PIN_CFG_LO)
      decode = FTG_SEL_PIN_CFG_LO;
    else if (idx == `FTG_IDX_UNLOCK)
      decode = FTG_SEL_UNLOCK;
    else if (idx == `FTG_IDX_STATUS)
      decode = FTG_SEL_STATUS;
    else
      decode = FTG_SEL_NONE;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  ftg_sel_t sel; // Register addressed by the current transfer.
  logic wr_acc; // Write completing at this edge.
  logic setup; // Setup phase of any transfer.
  ftg_byte_t wbyte; // Low byte of the write data.
  logic soft_rst; // One-cycle software reset of unlocked registers.
  logic wr_en; // Writes allowed to lockable registers.
  ftg_byte_t fan_mode_q; // Fan mode register.
  ftg_byte_t misc_q; // Miscellaneous control register.
  ftg_byte_t speed_en_q; // Per-input measurement enables.
  logic [3:0] pair_cont_q; // Continuous measurement per input pair.
  ftg_byte_t pin_cfg_q; // Pin polarity and direction for pins 1 to 4.
  logic lock_q; // Write-once lock, cleared only by power-up reset.
  logic key_ok_q; // Unlock key seen, soft reset armed.
  logic ci_clr_q; // Intrusion latch clear pulse.
  logic [31:0] prdata_q; // Read data captured in the setup phase.
  logic [26:0] meas_cnt_q; // Measurement interval counter.
  logic tick_q; // Measurement strobe.
  logic [26:0] meas_limit; // Current interval length minus one.
  logic vr1_hot; // Regulator one hot, synchronised.
  logic vr2_hot; // Regulator two hot, synchronised.
  logic [3:0] pin_raw; // Pin inputs, synchronised.
  logic [3:0] pin_pol; // Polarity bits, 1 meaning active high.
  logic [3:0] pin_dir; // Direction bits, 1 meaning output.

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  assign sel = decode(paddr);
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign wbyte = pwdata[7:0];

  // No wait states: every access completes in its first access cycle.
  assign pready = 1'b1;

  // Unmapped or misaligned addresses answer with an error.
  assign pslverr = psel & penable & (sel == FTG_SEL_NONE);

  // Locked registers silently ignore writes; the bus sees no error.
  assign wr_en = ~lock_q;

  // Read data is captured one edge early so prdata comes from a flop.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (setup && !pwrite)
    begin
      case (sel)
        FTG_SEL_BANK_CTRL:
          prdata_q <= {24'h000000, 1'b0, lock_q, 6'h00};
        FTG_SEL_FAN_MODE:
          prdata_q <= {24'h000000, fan_mode_q};
        FTG_SEL_MISC_CTRL:
          prdata_q <= {24'h000000, misc_q};
        FTG_SEL_SPEED_EN:
          prdata_q <= {24'h000000, speed_en_q};
        FTG_SEL_SPEED_CFG:
          prdata_q <= {28'h0000000, pair_cont_q};
        FTG_SEL_PIN_CFG_LO:
          prdata_q <= {24'h000000, pin_cfg_q};
        FTG_SEL_STATUS:
          prdata_q <= {24'h000000, vr1_hot, vr2_hot, fan_full_speed_o,
                       key_ok_q, gpio_state_o};
        default:
          prdata_q <= 32'h00000000;
      endcase
    end
  end
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Lock and software reset.

  // Lock sets once and only power-up reset clears it.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      lock_q <= 1'b0;
    else if (wr_acc && sel == FTG_SEL_BANK_CTRL && wbyte[`FTG_B_LOCK])
      lock_q <= 1'b1;
  end

  // The key arms a single soft reset; any other unlock write disarms it.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      key_ok_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      key_ok_q <= 1'b0;
    end
    else if (wr_acc && sel == FTG_SEL_UNLOCK)
    begin
      key_ok_q <= (wbyte == `FTG_UNLOCK_KEY);
    end
  end

  // A locked bank is wholly unaffected by soft reset, since all is lockable.
  assign soft_rst = wr_acc & (sel == FTG_SEL_BANK_CTRL) & wbyte[`FTG_B_SWRST]
                    & key_ok_q & wr_en;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Fan mode register.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      fan_mode_q <= `FTG_RST_FAN_MODE;
    else if (soft_rst)
      fan_mode_q <= `FTG_RST_FAN_MODE;
    else if (wr_acc && wr_en && sel == FTG_SEL_FAN_MODE)
      fan_mode_q <= wbyte;
  end

  // Miscellaneous control; the intrusion clear bit never stores a one.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      misc_q <= `FTG_RST_MISC_CTRL;
    else if (soft_rst)
      misc_q <= `FTG_RST_MISC_CTRL;
    else if (wr_acc && wr_en && sel == FTG_SEL_MISC_CTRL)
      misc_q <= wbyte & ~(8'h01 << `FTG_B_CI_CLR);
  end

  // One-cycle clear of the intrusion latch on each write of a one while the bank is unlocked.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ci_clr_q <= 1'b0;
    end
    else
    begin
      ci_clr_q <= wr_acc & wr_en & (sel == FTG_SEL_MISC_CTRL)
                  & wbyte[`FTG_B_CI_CLR];
    end
  end

  // Measurement enables, one per input.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      speed_en_q <= `FTG_RST_SPEED_EN;
    else if (soft_rst)
      speed_en_q <= `FTG_RST_SPEED_EN;
    else if (wr_acc && wr_en && sel == FTG_SEL_SPEED_EN)
      speed_en_q <= wbyte;
  end

  // Continuous measurement pairs; the upper nibble is not stored.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pair_cont_q <= 4'(`FTG_RST_SPEED_CFG);
    else if (soft_rst)
      pair_cont_q <= 4'(`FTG_RST_SPEED_CFG);
    else if (wr_acc && wr_en && sel == FTG_SEL_SPEED_CFG)
      pair_cont_q <= wbyte[3:0];
  end

  // Pin polarity and direction for pins 1 to 4.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pin_cfg_q <= `FTG_RST_PIN_CFG_LO;
    else if (soft_rst)
      pin_cfg_q <= `FTG_RST_PIN_CFG_LO;
    else if (wr_acc && wr_en && sel == FTG_SEL_PIN_CFG_LO)
      pin_cfg_q <= wbyte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Regulator hot inputs are active high and asynchronous.
  ftg_sync3 #(.W(2)) u_vr_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_i({regulator_one_hot_in, regulator_two_hot_in}),
    .level_o({vr1_hot, vr2_hot})
  );

  // General purpose pin inputs.
  ftg_sync3 #(.W(4)) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_i(gpio_in),
    .level_o(pin_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fan control outputs.

  // Any enabled boost source or the override drives fans full.
  assign fan_full_speed_o = fan_mode_q[`FTG_B_FULL]
                            | (~fan_mode_q[`FTG_B_BOOST1] & vr1_hot)
                            | (~fan_mode_q[`FTG_B_BOOST2] & vr2_hot);
  assign pwm_high_freq_o = fan_mode_q[`FTG_B_PWM_MODE];

  // Field 00..11 maps to one to four pulses after the second edge.
  assign speed_pulse_count_o = {1'b0, fan_mode_q[`FTG_B_PULSES_MSB:`FTG_B_PULSES_LSB]}
                               + 3'd1;
  assign fan_speed_input_enable_o = speed_en_q;
  assign continuous_measure_o = {pair_cont_q, pair_cont_q};

  // Interval is a quarter of a second with the fast bit in low frequency.
  assign meas_limit = (fan_mode_q[`FTG_B_FAST] && !fan_mode_q[`FTG_B_PWM_MODE])
                      ? 27'(MEAS_CYCLES / `FTG_FAST_DIV - 1)
                      : 27'(MEAS_CYCLES - 1);

  // Measurement strobe; a shortened interval takes effect at once.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meas_cnt_q <= 27'h0000000;
      tick_q <= 1'b0;
    end
    else if (meas_cnt_q >= meas_limit)
    begin
      meas_cnt_q <= 27'h0000000;
      tick_q <= 1'b1;
    end
    else
    begin
      meas_cnt_q <= meas_cnt_q + 27'h0000001;
      tick_q <= 1'b0;
    end
  end
  assign measure_tick_o = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Miscellaneous outputs.

  assign general_pin_enable_o = misc_q[`FTG_B_PIN_EN];
  assign scl_timeout_en_o = misc_q[`FTG_B_SCL_TO];
  assign sda_timeout_en_o = misc_q[`FTG_B_SDA_TO];
  assign voltage_id_low_level_sel = misc_q[`FTG_B_VOLT_ID_LOW];
  assign thermal_in_low_level_sel = misc_q[`FTG_B_THERMAL_LOW];
  assign intrusion_latch_clear = ci_clr_q;
  assign xor_tree_en_o = misc_q[`FTG_B_XOR];
  assign vcore_low_en_o = misc_q[`FTG_B_VCORE];
  assign lock_o = lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // General purpose pins 1 to 4.

  assign pin_pol = {pin_cfg_q[6], pin_cfg_q[4], pin_cfg_q[2], pin_cfg_q[0]};
  assign pin_dir = {pin_cfg_q[7], pin_cfg_q[5], pin_cfg_q[3], pin_cfg_q[1]};

  // Pins drive only when the function is on and the pin is an output.
  assign gpio_oe = pin_dir & {4{misc_q[`FTG_B_PIN_EN]}};

  // An active-low pin inverts the logical level in both directions.
  assign gpio_out = ~(gpio_level_i ^ pin_pol);
  assign gpio_state_o = ~(pin_raw ^ pin_pol);

endmodule : ftg_cfg_regs

`default_nettype wire

// ---- dv/ftg_chk_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ftg_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Port-level watcher for the configuration bank.
// It sees the top module's ports only.
module ftg_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [3:0] gpio_oe,
  input wire logic fan_full_speed_o,
  input wire logic pwm_high_freq_o,
  input wire logic [2:0] speed_pulse_count_o,
  input wire logic [7:0] fan_speed_input_enable_o,
  input wire logic [7:0] continuous_measure_o,
  input wire logic general_pin_enable_o,
  input wire logic intrusion_latch_clear,
  input wire logic lock_o
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // An access edge that may change a register, since the bank is unlocked.
  sequence wr_s(logic [9:0] idx);
    psel && penable && pwrite && pready && paddr == {idx, 2'b00} && !lock_o;
  endsequence
  // Any write access once the bank is frozen.
  sequence locked_wr_s;
    psel && penable && pwrite && pready && lock_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  clear_pulse_a: assert property (intrusion_latch_clear |=> !intrusion_latch_clear)
    else $error("intrusion clear pulse too long");
  clear_cause_a: assert property (wr_s(`FTG_IDX_MISC_CTRL) ##0 pwdata[5] |=>
    intrusion_latch_clear) else $error("intrusion clear pulse missing");
  pulse_range_a: assert property (speed_pulse_count_o inside {[3'h1:3'h4]})
    else $error("pulse count out of range");
  pin_drive_a: assert property (gpio_oe != 4'h0 |-> general_pin_enable_o)
    else $error("pin driven while pins disabled");
  en_write_a: assert property (wr_s(`FTG_IDX_SPEED_EN) |=>
    fan_speed_input_enable_o == $past(pwdata[7:0])) else $error("enable write lost");
  mode_write_a: assert property (wr_s(`FTG_IDX_FAN_MODE) |=>
    pwm_high_freq_o == $past(pwdata[2]) &&
    speed_pulse_count_o == {1'b0, $past(pwdata[7:6])} + 3'h1) else $error("fan mode write lost");
  full_force_a: assert property (wr_s(`FTG_IDX_FAN_MODE) ##0 pwdata[5] |=>
    fan_full_speed_o) else $error("full speed not forced");
  lock_stick_a: assert property (lock_o |=> lock_o)
    else $error("lock released");
  lock_hold_a: assert property (locked_wr_s |=> $stable(fan_speed_input_enable_o) &&
    $stable(pwm_high_freq_o)) else $error("locked register changed");
  pair_write_a: assert property (wr_s(`FTG_IDX_SPEED_CFG) |=>
    continuous_measure_o == {2{$past(pwdata[3:0])}}) else $error("pair write lost");
endmodule : ftg_chk
`default_nettype wire

// ---- dv/ftg_pin_board.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Board model: pins and regulator hot lines seen by the bank.
module ftg_pin_board (
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] ext_level,
  input wire logic [1:0] hot_cmd,
  output logic [3:0] gpio_in,
  output logic regulator_one_hot_in,
  output logic regulator_two_hot_in
);
  // A pin shows the bank's drive while enabled, else the board's own level.
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
  // Hot lines are level signals, active high.
  assign regulator_one_hot_in = hot_cmd[0];
  assign regulator_two_hot_in = hot_cmd[1];
endmodule : ftg_pin_board
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ftg_regs.svh"
module tb_top;
  localparam logic [11:0] A_BANK = 12'h004, A_FAN = 12'h008, A_MISC = 12'h00C;
  localparam logic [11:0] A_EN = 12'h01C, A_CFG = 12'h020, A_PIN = 12'h024;
  localparam logic [11:0] A_KEY = 12'h1EC, A_BAD = 12'h100;
  logic clk_sys = 1'b0, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [3:0] gpio_in, gpio_out, gpio_oe, gpio_level_i, gpio_state_o, ext_level;
  logic [1:0] hot_cmd;
  logic regulator_one_hot_in, regulator_two_hot_in, fan_full_speed_o, pwm_high_freq_o;
  logic [2:0] speed_pulse_count_o;
  logic measure_tick_o, general_pin_enable_o, scl_timeout_en_o, sda_timeout_en_o;
  logic [7:0] fan_speed_input_enable_o, continuous_measure_o;
  logic voltage_id_low_level_sel, thermal_in_low_level_sel, intrusion_latch_clear;
  logic xor_tree_en_o, vcore_low_en_o, lock_o, rerr;
  int num_errors = 0, check_count = 0, ticks = 0, clears = 0, t0;
  logic [11:0] ra [5] = '{A_FAN, A_MISC, A_EN, A_CFG, A_PIN};
  logic [7:0] rv [5] = '{`FTG_RST_FAN_MODE, `FTG_RST_MISC_CTRL, `FTG_RST_SPEED_EN,
    `FTG_RST_SPEED_CFG, `FTG_RST_PIN_CFG_LO};
  always #5 clk_sys = ~clk_sys;
  // Ticks are counted on the falling edge, away from the sampling edge.
  always @(negedge clk_sys) if (measure_tick_o === 1'b1) ticks++;
  // Intrusion clear pulses are counted the same way, so a long pulse counts twice.
  always @(negedge clk_sys) if (intrusion_latch_clear === 1'b1) clears++;
  ftg_cfg_regs #(.MEAS_CYCLES(40)) DUT (.clk_sys, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .regulator_one_hot_in,
    .regulator_two_hot_in, .gpio_in, .gpio_out, .gpio_oe, .gpio_level_i, .gpio_state_o,
    .fan_full_speed_o, .pwm_high_freq_o, .speed_pulse_count_o, .measure_tick_o,
    .fan_speed_input_enable_o, .continuous_measure_o, .general_pin_enable_o,
    .scl_timeout_en_o, .sda_timeout_en_o, .voltage_id_low_level_sel,
    .thermal_in_low_level_sel, .intrusion_latch_clear, .xor_tree_en_o, .vcore_low_en_o,
    .lock_o);
  ftg_pin_board board (.gpio_out, .gpio_oe, .ext_level, .hot_cmd, .gpio_in,
    .regulator_one_hot_in, .regulator_two_hot_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; only the watchdog ends the wait on a silent slave.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rdq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("readback", rdq, {24'h000000, e});
  endtask : rc
  // Tick rate over a 400-cycle window, after letting a new setting settle.
  task automatic tk(input int e);
    repeat (50) @(posedge clk_sys);
    t0 = ticks;
    repeat (400) @(posedge clk_sys);
    chk("ticks", ticks - t0, e);
  endtask : tk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    {resetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {gpio_level_i, ext_level, hot_cmd} <= '0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) rc(ra[i], rv[i]);
    chk("pulses", speed_pulse_count_o, 32'h3);
    chk("pairs", continuous_measure_o, 32'hFF);
    $display("test reset values done");
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, A_FAN, {k[1:0], 6'h04});
      chk("pulses", speed_pulse_count_o, k + 1);
      chk("mode", pwm_high_freq_o, 32'h1);
    end
    apb(1'b1, A_FAN, 8'h20);
    chk("full", fan_full_speed_o, 32'h1);
    chk("mode", pwm_high_freq_o, 32'h0);
    // Regulator boosts: each hot line forces full speed only while unmasked.
    apb(1'b1, A_FAN, 8'h80);
    hot_cmd <= 2'b01;
    repeat (6) @(posedge clk_sys);
    chk("full", fan_full_speed_o, 32'h1);
    apb(1'b1, A_FAN, 8'h88);
    chk("full", fan_full_speed_o, 32'h0);
    hot_cmd <= 2'b10;
    repeat (6) @(posedge clk_sys);
    chk("full", fan_full_speed_o, 32'h1);
    apb(1'b1, A_FAN, 8'h98);
    chk("full", fan_full_speed_o, 32'h0);
    hot_cmd <= 2'b00;
    $display("test fan mode done");
    apb(1'b1, A_FAN, 8'h80);
    tk(10);
    apb(1'b1, A_FAN, 8'h81);
    tk(40);
    apb(1'b1, A_FAN, 8'h85);
    tk(10);
    $display("test measure rate done");
    apb(1'b1, A_MISC, 8'hDF);
    chk("misc", {vcore_low_en_o, xor_tree_en_o, thermal_in_low_level_sel,
      voltage_id_low_level_sel, sda_timeout_en_o, scl_timeout_en_o,
      general_pin_enable_o}, 32'h7F);
    chk("clears", clears, 32'h0);
    apb(1'b1, A_MISC, 8'h20);
    chk("clears", clears, 32'h1);
    rc(A_MISC, 8'h00);
    chk("misc", {xor_tree_en_o, sda_timeout_en_o, scl_timeout_en_o}, 32'h0);
    apb(1'b1, A_EN, 8'hA5);
    chk("enables", fan_speed_input_enable_o, 32'hA5);
    apb(1'b1, A_CFG, 8'hF5);
    rc(A_CFG, 8'h05);
    chk("pairs", continuous_measure_o, 32'h55);
    // Pin 1 active-high output, pin 2 active-low output, pins 3 and 4 inputs.
    apb(1'b1, A_MISC, 8'h01);
    apb(1'b1, A_PIN, 8'h0B);
    gpio_level_i <= 4'hF;
    ext_level <= 4'h4;
    repeat (6) @(posedge clk_sys);
    chk("oe", gpio_oe, 32'h3);
    chk("out", gpio_out[1:0], 32'h1);
    chk("state", gpio_state_o, 32'hB);
    $display("test control bits done");
    // A soft reset needs the key first.
    apb(1'b1, A_BANK, 8'h80);
    rc(A_EN, 8'hA5);
    apb(1'b1, A_KEY, `FTG_UNLOCK_KEY);
    apb(1'b1, A_BANK, 8'h80);
    rc(A_FAN, 8'h80);
    rc(A_EN, 8'h00);
    rc(A_CFG, 8'h0F);
    apb(1'b0, A_BAD, 8'h00);
    chk("slverr", rerr, 32'h1);
    chk("bad read", rdq, 32'h0);
    apb(1'b1, A_BANK, 8'h40);
    apb(1'b1, A_EN, 8'h3C);
    rc(A_EN, 8'h00);
    apb(1'b1, A_MISC, 8'h20);
    chk("clears", clears, 32'h1);
    apb(1'b1, A_BANK, 8'h00);
    chk("lock", lock_o, 32'h1);
    $display("test reset and lock done");
    report_and_stop();
  end
endmodule : tb_top
bind ftg_cfg_regs ftg_chk u_chk (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .gpio_oe, .fan_full_speed_o, .pwm_high_freq_o, .speed_pulse_count_o,
  .fan_speed_input_enable_o, .continuous_measure_o, .general_pin_enable_o,
  .intrusion_latch_clear, .lock_o);
`default_nettype wire
